// [scan_master_host_port.sv]
// Device end of the scan master host port: strobe timed register file
`include "scan_port_defs.svh"
module scan_master_host_port
  import scan_port_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  scan_host_if.dev       bus,
  // Engine side
  output reg_data_t      config_a_o,
  output reg_data_t      config_b_o,
  output reg_data_t      command_o,
  output logic           cmd_start_o,
  output logic           soft_reset_o,
  input  wire logic      cmd_done_i,
  input  wire logic      full_duplex_i,
  input  wire logic      capture_empty_i,
  input  wire logic      shift_out_block_i,
  input  wire logic      counter_state_i,
  input  wire logic [3:0] tap_state_i,
  output reg_data_t      shift_out_data_o,
  output logic           shift_out_wr_o,
  input  wire reg_data_t capture_data_i,
  output logic           capture_rd_o,
  output reg_data_t      counter_data_o,
  output logic           counter_wr_o,
  input  wire reg_data_t counter_data_i,
  output logic [3:0]     direct_ctrl_o
);
  import scan_port_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [11:0] pin_meta_reg;
  logic [11:0] pin_sync_reg;
  logic [2:0]  host_strobe_n_pipe_reg;
  logic        host_strobe_n_fall;
  logic        host_strobe_n_rise;
  logic        acc_read;
  reg_addr_t   acc_addr;
  reg_data_t   acc_wdata;

  // Two stages on every pin before use; third strobe stage finds edges
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_reg  <= 12'h000;
      pin_sync_reg  <= 12'h000;
      host_strobe_n_pipe_reg <= 3'h7;
    end
    else
    begin
      pin_meta_reg  <= {bus.read_sel, bus.addr, bus.data_bus};
      pin_sync_reg  <= pin_meta_reg;
      host_strobe_n_pipe_reg <= {host_strobe_n_pipe_reg[1:0], bus.host_strobe_n};
    end
  end

  // Edges are seen only from the synchronised strobe, never from clk phase
  assign host_strobe_n_fall = host_strobe_n_pipe_reg[2] & ~host_strobe_n_pipe_reg[1];
  assign host_strobe_n_rise = ~host_strobe_n_pipe_reg[2] & host_strobe_n_pipe_reg[1];
  // Select and address taken as stable for the whole low phase
  assign acc_read  = pin_sync_reg[11];
  assign acc_addr  = pin_sync_reg[10:8];
  assign acc_wdata = pin_sync_reg[7:0];

  // ----------------------------------------
  // Blocking conditions
  // ----------------------------------------
  dev_state_t state_reg;
  dev_state_t state_next;
  reg_data_t  config_a_reg;
  reg_data_t  config_a_next;
  reg_data_t  config_b_reg;
  reg_data_t  config_b_next;
  reg_data_t  command_reg;
  reg_data_t  command_next;
  reg_data_t  shift_out_reg;
  reg_data_t  shift_out_next;
  logic [3:0] direct_reg;
  logic [3:0] direct_next;
  logic [2:0] lead_reg;
  logic [2:0] lead_next;
  reg_data_t  rdata_reg;
  reg_data_t  rdata_next;
  logic       ready_reg;
  logic       ready_next;
  logic       oe_n_reg;
  logic       oe_n_next;
  logic       busy;
  logic       lead_full;
  logic       blocked;
  reg_data_t  status_val;
  reg_data_t  read_val;

  assign busy      = |command_reg[3:0];
  // Lead limit applies only with a retiming delay in full duplex
  assign lead_full = full_duplex_i && (|config_b_reg[3:0]) && (lead_reg >= `LEAD_LIMIT);

  // Status shows the capture-empty and shift-out-block stall causes, not busy or the lead limit, so software can poll instead of wait
  assign status_val = {capture_empty_i, shift_out_block_i, counter_state_i,
                       1'b0, tap_state_i};

  // Stall decision for the access now on the pins
  always_comb
  begin
    blocked = 1'b0;
    if (acc_read)
    begin
      blocked = (acc_addr == `OFS_CAPTURE_BUFFER) && capture_empty_i;
    end
    else
    begin
      unique case (acc_addr)
        `OFS_SHIFT_OUT_BUFFER:
          blocked = shift_out_block_i || lead_full;
        `OFS_ENGINE_COMMAND:
          blocked = busy && !acc_wdata[`BIT_SOFT_RESET];
        `OFS_SCAN_CONFIG_A, `OFS_SCAN_CONFIG_B, `OFS_CYCLE_COUNTER_PORT:
          blocked = busy;
        default:
          blocked = 1'b0;
      endcase
    end
  end

  // Read data mux over all eight registers
  always_comb
  begin
    unique case (acc_addr)
      `OFS_SCAN_CONFIG_A:      read_val = config_a_reg;
      `OFS_SCAN_CONFIG_B:      read_val = config_b_reg;
      `OFS_ENGINE_STATUS:      read_val = status_val;
      `OFS_ENGINE_COMMAND:     read_val = command_reg;
      `OFS_SHIFT_OUT_BUFFER:   read_val = shift_out_reg;
      `OFS_CAPTURE_BUFFER:     read_val = capture_data_i;
      `OFS_CYCLE_COUNTER_PORT: read_val = counter_data_i;
      default:                 read_val = {4'h0, direct_reg};
    endcase
  end

  // ----------------------------------------
  // Access sequencer and registers
  // ----------------------------------------
  // Writes commit on the rising strobe; an aborted stall commits nothing
  always_comb
  begin
    state_next     = state_reg;
    config_a_next  = config_a_reg;
    config_b_next  = config_b_reg;
    command_next   = command_reg;
    shift_out_next = shift_out_reg;
    direct_next    = direct_reg;
    lead_next      = lead_reg;
    rdata_next     = rdata_reg;
    cmd_start_o    = 1'b0;
    soft_reset_o   = 1'b0;
    shift_out_wr_o = 1'b0;
    capture_rd_o   = 1'b0;
    counter_wr_o   = 1'b0;
    if (cmd_done_i)
    begin
      command_next[3:0] = 4'h0;
    end
    unique case (state_reg)
      DEV_IDLE:
        if (host_strobe_n_fall)
        begin
          state_next = blocked ? DEV_STALL : DEV_ACTIVE;
          rdata_next = read_val;
        end
      DEV_STALL:
        if (host_strobe_n_rise)
        begin
          state_next = DEV_IDLE;
        end
        else if (!blocked)
        begin
          state_next = DEV_ACTIVE;
          rdata_next = read_val;
        end
      DEV_ACTIVE:
        if (host_strobe_n_rise)
        begin
          state_next = DEV_IDLE;
          if (acc_read)
          begin
            if (acc_addr == `OFS_CAPTURE_BUFFER)
            begin
              capture_rd_o = 1'b1;
              lead_next    = (lead_reg != 3'h0) ? lead_reg - 3'h1 : 3'h0;
            end
          end
          else
          begin
            unique case (acc_addr)
              `OFS_SCAN_CONFIG_A:      config_a_next = acc_wdata;
              `OFS_SCAN_CONFIG_B:      config_b_next = acc_wdata;
              `OFS_CYCLE_COUNTER_PORT: counter_wr_o  = 1'b1;
              `OFS_SHIFT_OUT_BUFFER:
              begin
                shift_out_next = acc_wdata;
                shift_out_wr_o = 1'b1;
                lead_next      = lead_reg + 3'h1;
              end
              `OFS_ENGINE_COMMAND:
                if (acc_wdata[`BIT_SOFT_RESET])
                begin
                  soft_reset_o = 1'b1;
                  command_next = `RST_ENGINE_COMMAND;
                  lead_next    = 3'h0;
                end
                else
                begin
                  command_next = acc_wdata;
                  cmd_start_o  = |acc_wdata[3:0];
                  lead_next    = 3'h0;
                end
              `OFS_DIRECT_PIN_CONTROL:
                if (!busy)
                begin
                  direct_next = acc_wdata[3:0];
                end
              default:
                ; // Status and capture buffer ignore writes
            endcase
          end
        end
      default:
        state_next = DEV_IDLE;
    endcase
    // Drive only for reads, and only while the strobe is low
    oe_n_next  = !((state_next != DEV_IDLE) && acc_read);
    ready_next = (state_next != DEV_STALL);
  end

  // Register stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg     <= DEV_IDLE;
      config_a_reg  <= `RST_SCAN_CONFIG_A;
      config_b_reg  <= `RST_SCAN_CONFIG_B;
      command_reg   <= `RST_ENGINE_COMMAND;
      shift_out_reg <= `RST_SHIFT_OUT_BUFFER;
      direct_reg    <= `RST_DIRECT_PIN_CONTROL;
      lead_reg      <= 3'h0;
      rdata_reg     <= 8'h00;
      ready_reg     <= 1'b1;
      oe_n_reg      <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      config_a_reg  <= config_a_next;
      config_b_reg  <= config_b_next;
      command_reg   <= command_next;
      shift_out_reg <= shift_out_next;
      direct_reg    <= direct_next;
      lead_reg      <= lead_next;
      rdata_reg     <= rdata_next;
      ready_reg     <= ready_next;
      oe_n_reg      <= oe_n_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.dev_data      = rdata_reg;
  assign bus.dev_oe_n      = oe_n_reg;
  assign bus.ready         = ready_reg;
  assign config_a_o        = config_a_reg;
  assign config_b_o        = config_b_reg;
  assign command_o         = command_reg;
  assign shift_out_data_o  = shift_out_reg;
  assign counter_data_o    = acc_wdata; // Valid with counter_wr_o
  assign direct_ctrl_o     = direct_reg;

endmodule : scan_master_host_port

// [scan_port_defs.svh]
// Offsets, field positions, reset values and timing counts of the scan host port
`ifndef SCAN_PORT_DEFS_SVH
`define SCAN_PORT_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SCAN_CONFIG_A      3'h0
`define OFS_SCAN_CONFIG_B      3'h1
`define OFS_ENGINE_STATUS      3'h2
`define OFS_ENGINE_COMMAND     3'h3
`define OFS_SHIFT_OUT_BUFFER   3'h4
`define OFS_CAPTURE_BUFFER     3'h5
`define OFS_CYCLE_COUNTER_PORT 3'h6
`define OFS_DIRECT_PIN_CONTROL 3'h7
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define RST_SCAN_CONFIG_A      8'h00
`define RST_SCAN_CONFIG_B      8'h80
`define RST_ENGINE_COMMAND     8'h00
`define RST_SHIFT_OUT_BUFFER   8'h00
`define RST_DIRECT_PIN_CONTROL 4'h0
`define BIT_SOFT_RESET         7
`define BIT_CAPTURE_EMPTY      7
`define BIT_SHIFT_OUT_BLOCK    6
`define LEAD_LIMIT             3'h4
// ----------------------------------------
// Timing, at a 25 ns clock
// ----------------------------------------
`define CLK_PERIOD_NS          25
`define HOST_STROBE_N_LOW_MIN_NS        200
`define HOST_STROBE_N_LOW_MIN_CYC       ((`HOST_STROBE_N_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_STROBE_N_HIGH_MIN_NS       100
`define HOST_STROBE_N_HIGH_MIN_CYC      ((`HOST_STROBE_N_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAIT_TIMEOUT_NS        100000
`define WAIT_TIMEOUT_CYC       (`WAIT_TIMEOUT_NS / `CLK_PERIOD_NS)
`define READY_SETTLE_CYC       2
`endif

// [scan_port_pkg.sv]
// Types shared by both ends of the scan host port
package scan_port_pkg;
  typedef logic [2:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  // Device end access sequencer
  typedef enum logic [2:0] {
    DEV_IDLE   = 3'b001,
    DEV_STALL  = 3'b010,
    DEV_ACTIVE = 3'b100
  } dev_state_t;
  // Host end strobe sequencer
  typedef enum logic [4:0] {
    HST_IDLE  = 5'b00001,
    HST_SETUP = 5'b00010,
    HST_LOW   = 5'b00100,
    HST_HOLD  = 5'b01000,
    HST_HIGH  = 5'b10000
  } host_state_t;
endpackage : scan_port_pkg

// [scan_host_if.sv]
// Pins between host processor and scan master host port
interface scan_host_if;
  import scan_port_pkg::*;
  logic      host_strobe_n;
  logic      read_sel;
  reg_addr_t addr;
  reg_data_t host_data;
  logic      host_oe_n;
  reg_data_t dev_data;
  logic      dev_oe_n;
  logic      ready;
  wire [7:0] data_bus;
  // Bus level resolved from both output enables (low means driving)
  // Released bus settles to its pull-up level, so nothing floats
  assign data_bus = !dev_oe_n ? dev_data : (!host_oe_n ? host_data : 8'hFF);
  modport dev  (input host_strobe_n, read_sel, addr, data_bus,
                output dev_data, dev_oe_n, ready);
  modport host (output host_strobe_n, read_sel, addr, host_data, host_oe_n,
                input data_bus, ready);
endinterface : scan_host_if

// [scan_host_master.sv]
// Host end: turns single requests into strobed accesses on the scan port
`include "scan_port_defs.svh"
module scan_host_master
  import scan_port_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  scan_host_if.host      bus,
  input  wire logic      req_i,
  input  wire logic      req_read_i,
  input  wire reg_addr_t req_addr_i,
  input  wire reg_data_t req_wdata_i,
  output logic           busy_o,
  output logic           done_o,
  output logic           aborted_o,
  output reg_data_t      rdata_o
);
  import scan_port_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_reg <= 9'h000;
      pin_sync_reg <= 9'h000;
    end
    else
    begin
      pin_meta_reg <= {bus.ready, bus.data_bus};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------
  // Strobe sequencer
  // ----------------------------------------
  host_state_t state_reg;
  host_state_t state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic        read_reg;
  logic        read_next;
  reg_addr_t   addr_reg;
  reg_addr_t   addr_next;
  reg_data_t   wdata_reg;
  reg_data_t   wdata_next;
  reg_data_t   rdata_reg;
  reg_data_t   rdata_next;
  logic        abort_reg;
  logic        abort_next;
  logic        done_reg;
  logic        done_next;

  // Ready is ignored for the first cycles: the port needs time to pull it low
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 12'h001;
    read_next  = read_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    abort_next = abort_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      HST_IDLE:
        if (req_i)
        begin
          state_next = HST_SETUP;
          read_next  = req_read_i;
          addr_next  = req_addr_i;
          wdata_next = req_wdata_i;
          abort_next = 1'b0;
        end
      HST_SETUP:
      begin
        state_next = HST_LOW;
        cnt_next   = 12'h000;
      end
      HST_LOW:
        if (cnt_reg >= 12'(`WAIT_TIMEOUT_CYC))
        begin
          state_next = HST_HIGH;
          abort_next = 1'b1;
          cnt_next   = 12'h000;
        end
        else if ((cnt_reg >= 12'(`HOST_STROBE_N_LOW_MIN_CYC)) && pin_sync_reg[8])
        begin
          state_next = HST_HOLD;
          cnt_next   = 12'h000;
        end
      HST_HOLD:
        if (cnt_reg >= 12'(`READY_SETTLE_CYC))
        begin
          state_next = HST_HIGH;
          rdata_next = pin_sync_reg[7:0];
          cnt_next   = 12'h000;
        end
      HST_HIGH:
        if (cnt_reg >= 12'(`HOST_STROBE_N_HIGH_MIN_CYC))
        begin
          state_next = HST_IDLE;
          done_next  = 1'b1;
        end
      default:
        state_next = HST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= HST_IDLE;
      cnt_reg   <= 12'h000;
      read_reg  <= 1'b1;
      addr_reg  <= 3'h0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      abort_reg <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      read_reg  <= read_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      abort_reg <= abort_next;
      done_reg  <= done_next;
    end
  end

  // ----------------------------------------
  // Pins and user outputs
  // ----------------------------------------
  // Select and address stay put from setup through strobe release
  assign bus.host_strobe_n = !(state_reg == HST_LOW || state_reg == HST_HOLD);
  assign bus.read_sel      = read_reg;
  assign bus.addr          = addr_reg;
  assign bus.host_data     = wdata_reg;
  assign bus.host_oe_n     = (state_reg == HST_IDLE) || read_reg;
  assign busy_o            = (state_reg != HST_IDLE);
  assign done_o            = done_reg;
  assign aborted_o         = abort_reg;
  assign rdata_o           = rdata_reg;

endmodule : scan_host_master

// [scan_port_chk.sv]
// Concurrent checks on the pins between host end and device end
module scan_port_chk
(
  input wire logic                     clk_i,
  input wire logic                     rst_n_i,
  input wire logic                     host_strobe_n,
  input wire logic                     read_sel,
  input wire scan_port_pkg::reg_addr_t addr,
  input wire logic                     host_oe_n,
  input wire scan_port_pkg::reg_data_t dev_data,
  input wire logic                     dev_oe_n,
  input wire logic                     ready,
  input wire logic [7:0]               data_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  import scan_port_pkg::*;
  // Host wait limit plus a margin for strobe settling
  localparam int LOW_LIMIT = 4100;
  int unsigned low_cnt_reg;
  int unsigned low_cnt_next;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Strobe-low length, so a stuck access has a visible bound
  always_comb low_cnt_next = host_strobe_n ? 0 : low_cnt_reg + 1;
  always_ff @(posedge clk_i) low_cnt_reg <= rst_n_i ? low_cnt_next : 0;

  sequence strobe_fall;
    $fell(host_strobe_n);
  endsequence
  sequence read_start;
    strobe_fall ##0 read_sel;
  endsequence

  // ----------------------------------------
  // Pin checks
  // ----------------------------------------
  a_sel_stable: assert property (
    !host_strobe_n && !$past(host_strobe_n) |-> $stable(read_sel) && $stable(addr))
    else $error("Select or address moved under strobe");
  a_strobe_low_min: assert property (
    strobe_fall |-> !host_strobe_n [*8])
    else $error("Strobe low phase too short");
  a_strobe_high_min: assert property (
    $rose(host_strobe_n) |-> host_strobe_n [*4])
    else $error("Strobe high phase too short");
  a_read_drive: assert property (
    read_start |-> ##4 (!dev_oe_n || !ready))
    else $error("Read did not drive the bus");
  a_idle_hiz: assert property (
    host_strobe_n [*6] |-> dev_oe_n)
    else $error("Device drives bus with strobe high");
  a_write_no_drive: assert property (
    !read_sel [*6] |-> dev_oe_n)
    else $error("Device drives bus during write");
  a_no_bus_clash: assert property (
    !host_oe_n |-> dev_oe_n)
    else $error("Both ends drive the data bus");
  a_ready_in_access: assert property (
    $fell(ready) |-> !host_strobe_n)
    else $error("Ready fell outside an access");
  a_ready_idle: assert property (
    host_strobe_n [*8] |-> ready)
    else $error("Ready low while no access");
  a_ready_data: assert property (
    $rose(ready) && read_sel && !host_strobe_n |-> !dev_oe_n && data_bus == dev_data)
    else $error("Read data not on bus when ready rose");
  a_abort_bound: assert property (
    low_cnt_reg <= LOW_LIMIT)
    else $error("Stalled access never ended");
endmodule : scan_port_chk

// [testbench.sv]
// Self-checking bench joining the host end and the device end of the scan port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import scan_port_pkg::*;
  typedef struct packed {logic rd; reg_data_t data; logic ab;} note_t;
  note_t      notes[$];
  note_t      nt;
  logic       clk_i, rst_n_i, req_i, req_read_i, busy_o, done_o, aborted_o;
  logic       cmd_start_o, soft_reset_o, shift_out_wr_o, capture_rd_o, counter_wr_o;
  logic       cmd_done_i, full_duplex_i, capture_empty_i, shift_out_block_i, counter_state_i;
  logic [3:0] tap_state_i, direct_ctrl_o;
  reg_addr_t  req_addr_i;
  reg_data_t  req_wdata_i, rdata_o, config_a_o, config_b_o, command_o, shift_out_data_o;
  reg_data_t  counter_data_o, capture_data_i, counter_data_i, cnt_seen;
  reg_data_t  rv[8], wv[4];
  reg_addr_t  wa[4] = '{3'h0, 3'h1, 3'h4, 3'h7};
  reg_data_t  wm[4] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F};
  int         num_errors, checks, cycles, seed, n_start, n_soft, n_wr, n_rd;

  scan_host_if bus_if ();
  scan_host_master scan_host_master_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .req_i(req_i), .req_read_i(req_read_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .busy_o(busy_o), .done_o(done_o), .aborted_o(aborted_o), .rdata_o(rdata_o));
  scan_master_host_port scan_master_host_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus(bus_if), .config_a_o(config_a_o), .config_b_o(config_b_o), .command_o(command_o),
    .cmd_start_o(cmd_start_o), .soft_reset_o(soft_reset_o), .cmd_done_i(cmd_done_i),
    .full_duplex_i(full_duplex_i), .capture_empty_i(capture_empty_i),
    .shift_out_block_i(shift_out_block_i), .counter_state_i(counter_state_i),
    .tap_state_i(tap_state_i), .shift_out_data_o(shift_out_data_o),
    .shift_out_wr_o(shift_out_wr_o), .capture_data_i(capture_data_i),
    .capture_rd_o(capture_rd_o), .counter_data_o(counter_data_o), .counter_wr_o(counter_wr_o),
    .counter_data_i(counter_data_i), .direct_ctrl_o(direct_ctrl_o));
  scan_port_chk scan_port_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .host_strobe_n(bus_if.host_strobe_n), .read_sel(bus_if.read_sel), .addr(bus_if.addr),
    .host_oe_n(bus_if.host_oe_n), .dev_data(bus_if.dev_data), .dev_oe_n(bus_if.dev_oe_n),
    .ready(bus_if.ready), .data_bus(bus_if.data_bus));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input reg_data_t exp, input reg_data_t got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // One host request; the result is noted for the monitor to compare
  task automatic acc(input logic rd, input reg_addr_t a, input reg_data_t d,
                     input reg_data_t e, input logic ab);
    notes.push_back(note_t'{rd, e, ab});
    tick(1);
    {req_i, req_read_i, req_addr_i, req_wdata_i} = {1'b1, rd, a, d};
    tick(1);
    req_i = 1'b0;
    // A hang here is caught by the cycle ceiling in the monitor
    while (done_o !== 1'b1)
    begin
      tick(1);
    end
  endtask : acc

  task automatic pulse_done;
    cmd_done_i = 1'b1;
    tick(1);
    cmd_done_i = 1'b0;
  endtask : pulse_done

  task conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // Monitor: pulse tallies, result compares, hang ceiling
  // Sampled mid-cycle, where every output has settled
  always @(negedge clk_i)
  begin
    cycles++;
    n_start += cmd_start_o;
    n_soft += soft_reset_o;
    n_wr += shift_out_wr_o;
    n_rd += capture_rd_o;
    if (counter_wr_o === 1'b1) cnt_seen = counter_data_o;
    if (done_o === 1'b1)
    begin
      nt = notes.pop_front();
      chk("aborted_o", 8'(nt.ab), 8'(aborted_o));
      if (nt.rd) chk("rdata_o", nt.data, rdata_o);
    end
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {clk_i, rst_n_i, req_i, req_read_i, req_addr_i, req_wdata_i} = '0;
    {cmd_done_i, full_duplex_i, capture_empty_i, shift_out_block_i} = '0;
    seed = 32'h5A4C;
    counter_state_i = 1'($random(seed));
    tap_state_i = 4'($random(seed));
    capture_data_i = 8'($random(seed));
    counter_data_i = 8'($random(seed));
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    tick(3);
    // Reset values of all eight registers
    rv = '{8'h00, 8'h80, {2'h0, counter_state_i, 1'b0, tap_state_i}, 8'h00, 8'h00,
           capture_data_i, counter_data_i, 8'h00};
    for (int i = 0; i < 8; i++) acc(1'b1, 3'(i), 8'h00, rv[i], 1'b0);
    // Random write and read back; read-only places ignore writes
    for (int i = 0; i < 4; i++)
    begin
      wv[i] = 8'($random(seed)) & wm[i];
      acc(1'b0, wa[i], wv[i], 8'h00, 1'b0);
      acc(1'b1, wa[i], 8'h00, wv[i], 1'b0);
    end
    chk("config_a_o", wv[0], config_a_o);
    chk("config_b_o", wv[1], config_b_o);
    chk("shift_out_data_o", wv[2], shift_out_data_o);
    chk("direct_ctrl_o", wv[3], 8'(direct_ctrl_o));
    acc(1'b0, 3'h6, 8'h96, 8'h00, 1'b0);
    chk("counter_data_o", 8'h96, cnt_seen);
    acc(1'b0, 3'h2, 8'hC0, 8'h00, 1'b0);
    acc(1'b1, 3'h2, 8'h00, rv[2], 1'b0);
    acc(1'b0, 3'h5, 8'h5A, 8'h00, 1'b0);
    acc(1'b1, 3'h5, 8'h00, capture_data_i, 1'b0);
    // Running command: stalls, discards and the soft reset escape
    acc(1'b0, 3'h3, 8'h01, 8'h00, 1'b0);
    chk("command_o", 8'h01, command_o);
    acc(1'b1, 3'h3, 8'h00, 8'h01, 1'b0);
    acc(1'b0, 3'h7, ~wv[3] & 8'h0F, 8'h00, 1'b0);
    acc(1'b1, 3'h7, 8'h00, wv[3], 1'b0);
    fork
      acc(1'b0, 3'h0, 8'h5A, 8'h00, 1'b0);
      begin
        tick(60);
        chk("config_a_o", wv[0], config_a_o);
        chk("busy_o", 8'h01, 8'(busy_o));
        pulse_done();
      end
    join
    acc(1'b1, 3'h0, 8'h00, 8'h5A, 1'b0);
    acc(1'b0, 3'h3, 8'h02, 8'h00, 1'b0);
    acc(1'b0, 3'h3, 8'h80, 8'h00, 1'b0);
    acc(1'b1, 3'h3, 8'h00, 8'h00, 1'b0);
    // Capture read waits for data; shift-out write waits for room
    capture_empty_i = 1'b1;
    acc(1'b1, 3'h2, 8'h00, {2'h2, counter_state_i, 1'b0, tap_state_i}, 1'b0);
    fork
      acc(1'b1, 3'h5, 8'h00, 8'hC3, 1'b0);
      begin
        tick(50);
        {capture_data_i, capture_empty_i} = {8'hC3, 1'b0};
      end
    join
    shift_out_block_i = 1'b1;
    fork
      acc(1'b0, 3'h4, 8'h3C, 8'h00, 1'b0);
      begin
        tick(50);
        chk("shift_out_data_o", wv[2], shift_out_data_o);
        shift_out_block_i = 1'b0;
      end
    join
    chk("shift_out_data_o", 8'h3C, shift_out_data_o);
    // Full-duplex lead limit, then a host abort that commits nothing
    acc(1'b0, 3'h1, 8'h81, 8'h00, 1'b0);
    chk("config_b_o", 8'h81, config_b_o);
    full_duplex_i = 1'b1;
    acc(1'b0, 3'h3, 8'h02, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) acc(1'b0, 3'h4, 8'(i + 1), 8'h00, 1'b0);
    acc(1'b0, 3'h4, 8'hEE, 8'h00, 1'b1);
    chk("shift_out_data_o", 8'h04, shift_out_data_o);
    acc(1'b1, 3'h5, 8'h00, 8'hC3, 1'b0);
    acc(1'b0, 3'h4, 8'h77, 8'h00, 1'b0);
    pulse_done();
    full_duplex_i = 1'b0;
    tick(3);
    chk("cmd_start_o", 8'h03, 8'(n_start));
    chk("soft_reset_o", 8'h01, 8'(n_soft));
    chk("shift_out_wr_o", 8'h07, 8'(n_wr));
    chk("capture_rd_o", 8'h04, 8'(n_rd));
    chk("busy_o", 8'h00, 8'(busy_o));
    conclude();
  end
endmodule : testbench
